// ===== rtl/mped_top.sv
`include "mped_consts.svh"

module mped_top
  import mped_pkg::*;
#(
  parameter int                   WIDTH       = 16,
  parameter int                   DEPTH       = `MPED_DELAY_DEPTH,
  parameter int                   PHASE_LEN   = `MPED_PHASE_LEN,
  parameter logic [PHASE_LEN-1:0] PATTERN     = PHASE_LEN'(`MPED_PHASE_PATTERN),
  parameter bit                   EXT_CTRL    = 1'b0,
  parameter int                   BASE_PER_NS = `MPED_BASE_PERIOD_US * 1000,
  parameter int                   DERIV_MUL   = `MPED_DERIV_MUL,
  parameter int                   DERIV_DIV   = `MPED_DERIV_DIV,
  parameter int                   CLK_PER_NS  = 50
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // Optional external enable and synchronous clear
  input  wire logic             ext_ena_i,
  input  wire logic             ext_sclr_i,
  // Datapath
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] delay_o,
  output logic      [WIDTH-1:0] comb_o,
  output logic      [WIDTH-1:0] accum_o,
  // Status
  output logic                  phase_en_o,
  output logic                  slow_tick_o,
  output logic                  running_o
);

  // Derived period in nanoseconds, integer ratio only
  localparam int DERIV_PER_NS = (BASE_PER_NS * DERIV_MUL) / DERIV_DIV;

  initial begin
    if (DERIV_MUL < 1 || DERIV_DIV < 1) begin
      $error("Derived clock ratio terms must be positive");
    end
    if ((BASE_PER_NS * DERIV_MUL) % DERIV_DIV != 0) begin
      $error("Derived period must be a whole multiple of the base step");
    end
    if (PHASE_LEN < 1 || DEPTH < 1 || CLK_PER_NS < 1) begin
      $error("PHASE_LEN, DEPTH and CLK_PER_NS must be positive");
    end
    if (`MPED_BASE_SAMPLE_TIME != 1) begin
      $error("Default base sample time must be one");
    end
  end

  // Reset release through two flops; one reset per domain, shared by all
  // registers since this block has a single domain
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Run state after reset release
  mped_state_e state_ff;

  always_ff @(posedge clock_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= MPED_ST_RESET;
    end else begin
      unique case (state_ff)
        MPED_ST_RESET: state_ff <= MPED_ST_RUN;
        MPED_ST_RUN:   state_ff <= MPED_ST_RUN;
      endcase
    end
  end

  assign running_o = (state_ff == MPED_ST_RUN);

  // Phase selection
  logic phase_en;
  logic phase_wrap;

  mped_phase_gen #(
    .PHASE_LEN (PHASE_LEN),
    .PATTERN   (PATTERN)
  ) u_phase (
    .clock_i      (clock_i),
    .rst_n_i      (rst_sync_ff),
    .phase_en_o   (phase_en),
    .phase_wrap_o (phase_wrap)
  );

  assign phase_en_o = phase_en;

  // Enable and clear: wired internally unless exposed.
  // External enable is ANDed with the phase so it cannot add extra captures.
  logic dly_ena;
  logic dly_sclr;

  assign dly_ena  = EXT_CTRL ? (phase_en & ext_ena_i) : phase_en;
  assign dly_sclr = EXT_CTRL ? ext_sclr_i : 1'b0;

  // Delay register, enabled by the phase pattern
  mped_delay_line #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_delay (
    .clock_i (clock_i),
    .rst_n_i (rst_sync_ff),
    .ena_i   (dly_ena),
    .sclr_i  (dly_sclr),
    .data_i  (data_i),
    .data_o  (delay_o)
  );

  // Combinational path: same slot, no clock
  always_comb begin
    comb_o = data_i ^ delay_o;
  end

  // Feedback accumulator; loop closed through a register so it resolves
  logic [WIDTH-1:0] accum_ff;
  logic [WIDTH-1:0] nxt_accum;

  always_comb begin
    nxt_accum = accum_ff + delay_o;
  end

  always_ff @(posedge clock_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      accum_ff <= '0;
    end else if (dly_sclr) begin
      accum_ff <= '0;
    end else if (dly_ena) begin
      accum_ff <= nxt_accum;
    end
  end

  assign accum_o = accum_ff;

  // Slow-rate tick: one pulse per pattern period
  logic slow_tick_ff;

  always_ff @(posedge clock_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      slow_tick_ff <= 1'b0;
    end else begin
      slow_tick_ff <= phase_wrap;
    end
  end

  assign slow_tick_o = slow_tick_ff;

endmodule

// ===== rtl/mped_consts.svh
`ifndef MPED_CONSTS_SVH
`define MPED_CONSTS_SVH

// Default base clock period in microseconds and simulation sample time
`define MPED_BASE_PERIOD_US   20
`define MPED_BASE_SAMPLE_TIME 1
// Default phase pattern width and value: one bit, always enabled
`define MPED_PHASE_LEN        1
`define MPED_PHASE_PATTERN    1
// Default delay depth in sample slots
`define MPED_DELAY_DEPTH      1
// Default derived-clock ratio: multiply and divide
`define MPED_DERIV_MUL        1
`define MPED_DERIV_DIV        1
// Reset value of the delay line
`define MPED_DATA_RESET       0

`endif

// ===== rtl/mped_pkg.sv
package mped_pkg;
  typedef enum logic {
    MPED_ST_RESET,
    MPED_ST_RUN
  } mped_state_e;
endpackage

// ===== rtl/mped_phase_gen.sv
`include "mped_consts.svh"

module mped_phase_gen
  import mped_pkg::*;
#(
  parameter int                  PHASE_LEN = `MPED_PHASE_LEN,
  parameter logic [PHASE_LEN-1:0] PATTERN  = PHASE_LEN'(`MPED_PHASE_PATTERN)
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Phase enable
  output logic      phase_en_o,
  output logic      phase_wrap_o
);

  localparam int IDXW = (PHASE_LEN > 1) ? $clog2(PHASE_LEN) : 1;

  initial begin
    if (PHASE_LEN < 1) begin
      $error("PHASE_LEN must be at least 1");
    end
  end

  logic [IDXW-1:0] idx_ff;
  logic [IDXW-1:0] nxt_idx;
  logic            last;

  assign last = (idx_ff == IDXW'(PHASE_LEN - 1));

  // Pattern index advances one bit per fast cycle, wrapping after the last
  always_comb begin
    nxt_idx = last ? '0 : idx_ff + IDXW'(1);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_ff <= '0;
    end else begin
      idx_ff <= nxt_idx;
    end
  end

  // First printed digit is the first phase, stored in the top bit
  assign phase_en_o   = PATTERN[IDXW'(PHASE_LEN - 1) - idx_ff];
  assign phase_wrap_o = last;

endmodule

// ===== rtl/mped_delay_line.sv
`include "mped_consts.svh"

module mped_delay_line
  import mped_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = `MPED_DELAY_DEPTH
) (
  // Clock, reset and enable
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             ena_i,
  input  wire logic             sclr_i,
  // Data
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] data_o
);

  initial begin
    if (DEPTH < 1 || WIDTH < 1) begin
      $error("DEPTH and WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] stage_ff [DEPTH];

  // Shift chain; zero on reset so a decimating line starts clean
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_ff[i] <= WIDTH'(`MPED_DATA_RESET);
      end
    end else if (sclr_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_ff[i] <= WIDTH'(`MPED_DATA_RESET);
      end
    end else if (ena_i) begin
      stage_ff[0] <= data_i;
      for (int i = 1; i < DEPTH; i++) begin
        stage_ff[i] <= stage_ff[i-1];
      end
    end
  end

  assign data_o = stage_ff[DEPTH-1];

endmodule

// ===== verification/mped_top_sva.sv
module mped_top_sva #(parameter int WIDTH = 16) (
  // Design ports
  input wire logic             clock_i,
  input wire logic             nrst_i,
  input wire logic             ext_ena_i,
  input wire logic             ext_sclr_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic [WIDTH-1:0] delay_o,
  input wire logic [WIDTH-1:0] comb_o,
  input wire logic [WIDTH-1:0] accum_o,
  input wire logic             phase_en_o,
  input wire logic             slow_tick_o,
  input wire logic             running_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  logic hold;
  logic load;
  assign hold = running_o && !(phase_en_o && ext_ena_i) && !ext_sclr_i;
  assign load = running_o && phase_en_o && ext_ena_i && !ext_sclr_i;
  AST_COMB: assert property (comb_o == (data_i ^ delay_o))
    else $error("comb output not data xor delay");
  AST_LOAD: assert property (load |=> delay_o == $past(data_i))
    else $error("enabled sample not loaded");
  AST_HOLD: assert property (hold |=> $stable(delay_o) && $stable(accum_o))
    else $error("registers moved while disabled");
  AST_CLR: assert property (running_o && ext_sclr_i |=> delay_o == '0 && accum_o == '0)
    else $error("clear not applied");
  // Fixed to the four-phase pattern used on the bench
  AST_PHASE: assert property (running_o && phase_en_o |=> !phase_en_o [*3] ##1 phase_en_o)
    else $error("phase enable spacing wrong");
  AST_TICK: assert property (running_o && phase_en_o |-> ##3 slow_tick_o)
    else $error("wrap tick missing");
  AST_TICK_PH: assert property (slow_tick_o |-> !phase_en_o ##1 phase_en_o)
    else $error("tick not at first phase");
  AST_RUN: assert property ($rose(nrst_i) |-> !running_o ##1 !running_o ##[1:4] running_o)
    else $error("run start after reset wrong");
  cover property (load);
  cover property (running_o && ext_sclr_i);
  cover property (slow_tick_o);
endmodule

bind mped_top mped_top_sva #(.WIDTH(WIDTH)) mped_top_sva_i (.clock_i(clock_i), .nrst_i(nrst_i),
  .ext_ena_i(ext_ena_i), .ext_sclr_i(ext_sclr_i), .data_i(data_i), .delay_o(delay_o),
  .comb_o(comb_o), .accum_o(accum_o), .phase_en_o(phase_en_o), .slow_tick_o(slow_tick_o),
  .running_o(running_o));

// ===== verification/mped_src_model.sv
module mped_src_model #(parameter int WIDTH = 16) (
  // Clock
  input  wire logic        clock_i,
  // Sample stream
  output logic [WIDTH-1:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 32'h052EEB04;
  initial data_o = '0;
  // Upstream register stage: one new sample every fast clock
  always @(posedge clock_i) data_o <= WIDTH'($random(seed));
endmodule

// ===== verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         W   = 16;
  localparam logic [3:0] PAT = 4'h4;
  logic         clock_i;
  logic         nrst_i;
  logic         ena;
  logic         sclr;
  logic         ph;
  logic         tick;
  logic         run;
  logic [W-1:0] din;
  logic [W-1:0] dly;
  logic [W-1:0] cmb;
  logic [W-1:0] exp_d;
  logic [W-1:0] acc;
  logic [W-1:0] exp_a;
  logic [W-1:0] notes[$];
  logic [W-1:0] notes_a[$];
  int           fails;
  int           n_checks;
  int           k;
  int           cyc;
  int           seed = 32'h052EEB04;

  mped_top #(.WIDTH(W), .PHASE_LEN(4), .PATTERN(PAT), .EXT_CTRL(1'b1)) mped_top_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .ext_ena_i(ena), .ext_sclr_i(sclr), .data_i(din),
    .delay_o(dly), .comb_o(cmb), .accum_o(acc), .phase_en_o(ph), .slow_tick_o(tick),
    .running_o(run));
  mped_src_model #(.WIDTH(W)) mped_src_model_i (.clock_i(clock_i), .data_o(din));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic check(string nm, logic [W-1:0] seen, logic [W-1:0] expv);
    n_checks++;
    if (seen !== expv) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    nrst_i = 1'b0;
    ena = 1'b1;
    sclr = 1'b0;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 600; i++) begin
      @(posedge clock_i);
      ena <= ($random(seed) % 4) != 0;
      sclr <= ($random(seed) % 24) == 0;
      // Mid-run reset checks a clean restart of the phase index
      if (i == 300) nrst_i <= 1'b0;
      if (i == 303) nrst_i <= 1'b1;
    end
    print_verdict();
  end

  // Expected results noted before the edge that acts on them
  always @(negedge clock_i) begin
    if (!run) begin
      // Index has already stepped once when running first shows
      k = 1;
      exp_d = '0;
      exp_a = '0;
    end else begin
      check("phase", ph, PAT[3 - k % 4]);
      check("tick", tick, k >= 4 && k % 4 == 0);
      check("comb", cmb, din ^ dly);
      if (sclr) begin
        exp_a = '0;
        exp_d = '0;
      end else if (ena && PAT[3 - k % 4]) begin
        exp_a = exp_a + exp_d;
        exp_d = din;
      end
      notes.push_back(exp_d);
      notes_a.push_back(exp_a);
      k++;
    end
  end

  // Results taken once the edge's updates have landed
  always @(posedge clock_i) begin
    #1;
    cyc++;
    if (cyc > 2000) begin
      fails++;
      print_verdict();
    end
    if (!nrst_i) begin
      notes.delete();
      notes_a.delete();
      check("reset", dly, '0);
      check("reset_acc", acc, '0);
    end else if (notes.size() > 0) begin
      check("delay", dly, notes.pop_front());
      check("accum", acc, notes_a.pop_front());
    end
  end
endmodule
